// ---- nibble_cfg.svh ----
`ifndef NIBBLE_CFG_SVH
`define NIBBLE_CFG_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define DATA_W 32
`define BE_W 4
`define NIB_LANES 8
`define WORD_IDX_W 3
`define TAG_W 32
`define FIFO_DEPTH 8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TAG_RESET 32'h00000000
`define WORD_RESET 32'h00000000

// ----------------------------------------
// Operation codes
// ----------------------------------------
`define OP_NOP 4'h0
`define OP_READ 4'h1
`define OP_SL_NORM 4'h2
`define OP_SL_INIT 4'h3
`define OP_SF_NORM 4'h4
`define OP_SF_INIT 4'h5
`define OP_BLEND 4'h6
`define OP_TAG_REP 4'h7
`define OP_TAG_OR 4'h8
`define OP_CTRL_WR 4'h9
`define OP_ID_RD 4'hA

// ----------------------------------------
// Sequencer codes
// ----------------------------------------
`define SQ_IDLE 2'h0
`define SQ_ALU 2'h1
`define SQ_BACK 2'h3

`endif

// ---- nibble_pkg.sv ----
package nibble_pkg;
`include "nibble_cfg.svh"

    typedef enum logic [3:0] {
        K_NOP = `OP_NOP,
        K_READ = `OP_READ,
        K_SL_NORM = `OP_SL_NORM,
        K_SL_INIT = `OP_SL_INIT,
        K_SF_NORM = `OP_SF_NORM,
        K_SF_INIT = `OP_SF_INIT,
        K_BLEND = `OP_BLEND,
        K_TAG_REP = `OP_TAG_REP,
        K_TAG_OR = `OP_TAG_OR,
        K_CTRL_WR = `OP_CTRL_WR,
        K_ID_RD = `OP_ID_RD
    } op_kind_t;

    typedef enum logic [1:0] {
        SQ_IDLE = `SQ_IDLE,
        SQ_ALU = `SQ_ALU,
        SQ_BACK = `SQ_BACK
    } seq_t;

    typedef struct packed {
        op_kind_t kind;
        logic [`WORD_IDX_W-1:0] word;
        logic [`BE_W-1:0] be;
        logic [`DATA_W-1:0] data;
    } op_t;

    typedef struct packed {
        logic [`DATA_W-1:0] addend_new;
        logic [`DATA_W-1:0] mult_new;
        logic [`DATA_W-1:0] addend_old;
        logic [`DATA_W-1:0] mult_old;
    } alu_opnd_t;

    typedef struct packed {
        logic we;
        logic [`NIB_LANES-1:0] nib_en;
        logic [`DATA_W-1:0] data;
    } lane_wr_t;

endpackage

// ---- op_fifo.sv ----
`timescale 1ns/1ps
module op_fifo #(
    parameter int W = 43,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic full;
    } fifo_st_t;

    fifo_st_t s_q, s_d;
    logic push, pop;

    assign in_ready = !s_q.full;
    assign out_valid = s_q.cnt != '0;
    assign out_data = s_q.mem[s_q.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wp] = in_data;
            s_d.wp = (s_q.wp == AW'(DEPTH - 1)) ? '0 : s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = (s_q.rp == AW'(DEPTH - 1)) ? '0 : s_q.rp + 1'b1;
        end
        // Simultaneous push and pop keeps the count
        if (push && !pop) begin
            s_d.cnt = s_q.cnt + 1'b1;
        end else if (pop && !push) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
        // Registered so the ready output comes from a flop
        s_d.full = s_d.cnt == (AW+1)'(DEPTH);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end
endmodule

// ---- nibble_lane_map.sv ----
`timescale 1ns/1ps
`include "nibble_cfg.svh"

module nibble_lane_map
    import nibble_pkg::*;
#(
    parameter int DEPTH = `FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic mode_4444,
    input wire logic fmt_565,
    input wire logic op_valid,
    input wire op_t op_in,
    output logic op_ready,
    input wire logic [`DATA_W-1:0] pix_old,
    output alu_opnd_t alu_opnd,
    output logic alu_req,
    input wire logic alu_done,
    input wire logic [`DATA_W-1:0] alu_res,
    output lane_wr_t pix_wr,
    output logic rd_valid,
    output logic [`DATA_W-1:0] rd_data,
    output lane_wr_t reg_wr,
    output logic reg_rd,
    output logic [`TAG_W-1:0] dirty_tag,
    output logic alu_fault,
    output logic pair_fault,
    output logic mode_fault
);

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic logic [`NIB_LANES-1:0] lanes(
        input logic m4, input logic [`BE_W-1:0] be);
        logic [`NIB_LANES-1:0] n;
        n = '0;
        if (m4) begin
            // Buffer A on odd lanes, buffer B on even
            n = {be[3], be[1], be[3], be[1],
                 be[2], be[0], be[2], be[0]};
        end else begin
            for (int i = 0; i < `BE_W; i++) begin
                n[2*i+1] = be[i];
                n[2*i] = be[i];
            end
        end
        return n;
    endfunction

    function automatic logic [`DATA_W-1:0] nib_mask(
        input logic [`NIB_LANES-1:0] n);
        logic [`DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < `NIB_LANES; i++) begin
            m[4*i +: 4] = {4{n[i]}};
        end
        return m;
    endfunction

    // Byte-level tag enables for the addressed word
    function automatic logic [`BE_W-1:0] tag_be(
        input logic m4, input logic [`BE_W-1:0] be);
        logic hi, lo;
        hi = be[3] | be[1];
        lo = be[2] | be[0];
        if (m4) begin
            return {hi, hi, lo, lo};
        end
        return be;
    endfunction

    function automatic logic [`TAG_W-1:0] tag_upd(
        input logic [`TAG_W-1:0] t, input logic init,
        input logic [`WORD_IDX_W-1:0] w,
        input logic [`BE_W-1:0] tb);
        logic [`TAG_W-1:0] r;
        r = init ? '0 : t;
        // Normal write ORs, other words kept
        r[4*w +: 4] = init ? tb : (t[4*w +: 4] | tb);
        return r;
    endfunction

    function automatic logic is_alu(input op_kind_t k);
        return k == K_SF_NORM || k == K_SF_INIT || k == K_BLEND;
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        seq_t seq;
        op_t op;
        logic m4;
        alu_opnd_t opnd;
        logic alu_req;
        lane_wr_t pix;
        logic rd_valid;
        logic [`DATA_W-1:0] rd_data;
        lane_wr_t reg_w;
        logic reg_rd;
        logic [`TAG_W-1:0] tag;
        logic alu_fault;
        logic pair_fault;
        logic mode_fault;
    } st_t;

    st_t s_q, s_d;

    logic fifo_valid;
    logic fifo_pop;
    op_t fifo_op;

    op_fifo #(
        .W($bits(op_t)),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .in_valid(op_valid),
        .in_data(op_in),
        .in_ready(op_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_op),
        .out_ready(fifo_pop)
    );

    // Pull one operation only while idle; ALU ops hold the slot
    assign fifo_pop = s_q.seq == SQ_IDLE && fifo_valid;

    // ----------------------------------------
    // Operand widening
    // ----------------------------------------
    function automatic alu_opnd_t widen(
        input logic m4, input logic buf_a,
        input logic [`DATA_W-1:0] nd,
        input logic [`DATA_W-1:0] od);
        alu_opnd_t o;
        logic [3:0] cn, co;
        o = '0;
        for (int i = 0; i < `BE_W; i++) begin
            if (m4) begin
                // A in upper nibble, B in lower nibble
                cn = buf_a ? nd[8*i+4 +: 4] : nd[8*i +: 4];
                co = buf_a ? od[8*i+4 +: 4] : od[8*i +: 4];
                o.addend_new[8*i +: 8] = {cn, 4'h0};
                o.mult_new[8*i +: 8] = {cn, cn};
                o.addend_old[8*i +: 8] = {co, 4'h0};
                o.mult_old[8*i +: 8] = {co, co};
            end else begin
                // Alpha stays in byte 3 for the saturate path
                o.addend_new[8*i +: 8] = nd[8*i +: 8];
                o.mult_new[8*i +: 8] = nd[8*i +: 8];
                o.addend_old[8*i +: 8] = od[8*i +: 8];
                o.mult_old[8*i +: 8] = od[8*i +: 8];
            end
        end
        return o;
    endfunction

    // In 4444 mode, upper nibble of each result byte back to its buffer; 8888 result passes whole
    function automatic logic [`DATA_W-1:0] narrow(
        input logic m4, input logic buf_a,
        input logic [`DATA_W-1:0] r);
        logic [`DATA_W-1:0] d;
        d = r;
        if (m4) begin
            for (int i = 0; i < `BE_W; i++) begin
                d[8*i+4 +: 4] = buf_a ? r[8*i+4 +: 4] : 4'h0;
                d[8*i +: 4] = buf_a ? 4'h0 : r[8*i+4 +: 4];
            end
        end
        return d;
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    logic take_alu;
    logic buf_a;
    logic [`NIB_LANES-1:0] ln;

    always_comb begin
        s_d = s_q;
        s_d.alu_req = 1'b0;
        s_d.pix.we = 1'b0;
        s_d.rd_valid = 1'b0;
        s_d.reg_w.we = 1'b0;
        s_d.reg_rd = 1'b0;
        s_d.alu_fault = 1'b0;
        s_d.pair_fault = 1'b0;
        // 5-6-5 storage needs the 32-bit lane split
        s_d.mode_fault = fmt_565 && mode_4444;
        take_alu = 1'b0;
        buf_a = fifo_op.be[3] | fifo_op.be[2];
        ln = lanes(mode_4444, fifo_op.be);
        unique case (s_q.seq)
            SQ_IDLE: begin
                if (fifo_valid) begin
                    s_d.op = fifo_op;
                    s_d.m4 = mode_4444;
                    unique case (fifo_op.kind)
                        K_READ: begin
                            s_d.rd_valid = 1'b1;
                            s_d.rd_data = pix_old & nib_mask(ln);
                        end
                        K_SL_NORM, K_SL_INIT: begin
                            s_d.pix.we = 1'b1;
                            s_d.pix.nib_en = ln;
                            s_d.pix.data = fifo_op.data;
                            s_d.tag = tag_upd(s_q.tag,
                                fifo_op.kind == K_SL_INIT,
                                fifo_op.word,
                                tag_be(mode_4444, fifo_op.be));
                        end
                        K_SF_NORM, K_SF_INIT, K_BLEND: begin
                            take_alu = is_alu(fifo_op.kind);
                        end
                        K_TAG_REP: begin
                            s_d.tag = fifo_op.data;
                        end
                        K_TAG_OR: begin
                            s_d.tag = s_q.tag | fifo_op.data;
                        end
                        K_CTRL_WR: begin
                            s_d.reg_w.we = 1'b1;
                            s_d.reg_w.nib_en = lanes(1'b0, fifo_op.be);
                            s_d.reg_w.data = fifo_op.data;
                        end
                        K_ID_RD: begin
                            s_d.reg_rd = 1'b1;
                            s_d.reg_w.nib_en = lanes(1'b0, fifo_op.be);
                        end
                        default: begin
                        end
                    endcase
                    if (take_alu) begin
                        if (fmt_565) begin
                            // No blend path exists for 5-6-5 pixels
                            s_d.alu_fault = 1'b1;
                        end else begin
                            // Both buffers share one blend circuit
                            s_d.pair_fault = mode_4444 &&
                                ((fifo_op.be[3] && fifo_op.be[1]) ||
                                 (fifo_op.be[2] && fifo_op.be[0]));
                            s_d.opnd = widen(mode_4444, buf_a,
                                fifo_op.data, pix_old);
                            s_d.alu_req = 1'b1;
                            s_d.seq = SQ_ALU;
                        end
                    end
                end
            end
            SQ_ALU: begin
                if (alu_done) begin
                    s_d.seq = SQ_BACK;
                    // Blend initiation only loads the ALU
                    if (s_q.op.kind != K_BLEND) begin
                        s_d.pix.we = 1'b1;
                        s_d.pix.nib_en = lanes(s_q.m4, s_q.op.be);
                        s_d.pix.data = narrow(s_q.m4,
                            s_q.op.be[3] | s_q.op.be[2], alu_res);
                        s_d.tag = tag_upd(s_q.tag,
                            s_q.op.kind == K_SF_INIT, s_q.op.word,
                            tag_be(s_q.m4, s_q.op.be));
                    end
                end
            end
            SQ_BACK: begin
                // One spare cycle keeps the write from racing a read
                s_d.seq = SQ_IDLE;
            end
            default: begin
                s_d.seq = SQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.tag <= `TAG_RESET;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Tag word is exported unchanged by mode for block writes
    assign dirty_tag = s_q.tag;
    assign alu_opnd = s_q.opnd;
    assign alu_req = s_q.alu_req;
    assign pix_wr = s_q.pix;
    assign rd_valid = s_q.rd_valid;
    assign rd_data = s_q.rd_data;
    assign reg_wr = s_q.reg_w;
    assign reg_rd = s_q.reg_rd;
    assign alu_fault = s_q.alu_fault;
    assign pair_fault = s_q.pair_fault;
    assign mode_fault = s_q.mode_fault;
endmodule

// ---- nibble_assertions.sv ----
`timescale 1ns/1ps
// ----
// Port checks
// ----
module nibble_assertions
    import nibble_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic mode_4444,
    input wire logic fmt_565,
    input wire alu_opnd_t alu_opnd,
    input wire logic alu_req,
    input wire lane_wr_t pix_wr,
    input wire logic rd_valid,
    input wire lane_wr_t reg_wr,
    input wire logic reg_rd,
    input wire logic alu_fault,
    input wire logic mode_fault
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    function automatic bit p4(logic [7:0] n);
        return n[7] == n[5] && n[6] == n[4] && n[3] == n[1] && n[2] == n[0];
    endfunction

    function automatic bit p8(logic [7:0] n);
        return n[7] == n[6] && n[5] == n[4] && n[3] == n[2] && n[1] == n[0];
    endfunction

    a_mode_flag: assert property (
        clk_en |=> mode_fault == $past(fmt_565 && mode_4444))
        else $error("format clash flag wrong");
    a_refuse_quiet: assert property (
        alu_fault |-> !alu_req && !pix_wr.we)
        else $error("refused op still acted");
    a_no_blend_565: assert property (
        alu_req |-> !$past(fmt_565))
        else $error("blend started on 5-6-5 data");
    a_lanes_4444: assert property (
        pix_wr.we && mode_4444 && $past(mode_4444) |-> p4(pix_wr.nib_en))
        else $error("interleaved lane pairs broken");
    a_lanes_8888: assert property (
        pix_wr.we && !mode_4444 && !$past(mode_4444) |-> p8(pix_wr.nib_en))
        else $error("byte lane pairs broken");
    a_reg_decode: assert property (
        reg_wr.we |-> p8(reg_wr.nib_en))
        else $error("control write not byte decoded");
    a_id_decode: assert property (
        reg_rd |-> p8(reg_wr.nib_en))
        else $error("id read not byte decoded");
    a_one_result: assert property (
        rd_valid |-> !pix_wr.we && !reg_wr.we && !reg_rd)
        else $error("read overlapped another result");
    a_widen_opnd: assert property (
        alu_req && mode_4444 && $past(mode_4444) |->
        (alu_opnd.addend_new & 32'h0F0F0F0F) == 32'h00000000 &&
        ((alu_opnd.mult_new >> 4) & 32'h0F0F0F0F) ==
        (alu_opnd.mult_new & 32'h0F0F0F0F))
        else $error("operand widening wrong");
endmodule

bind nibble_lane_map nibble_assertions chk (.clock, .rst_n, .clk_en,
    .mode_4444, .fmt_565, .alu_opnd, .alu_req, .pix_wr, .rd_valid,
    .reg_wr, .reg_rd, .alu_fault, .mode_fault);

// ---- blend_alu_model.sv ----
`timescale 1ns/1ps
// ----
// Byte-wide blend units, answer lat+2 cycles after the request
// ----
module blend_alu_model
    import nibble_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] lat,
    input wire logic alu_req,
    input wire alu_opnd_t alu_opnd,
    output logic alu_done,
    output logic [31:0] alu_res
);
    logic busy_q;
    logic [7:0] cnt_q;
    logic [31:0] res_q;

    // Result bus toggles when idle so a stale sample never matches
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            cnt_q <= 8'h00;
            res_q <= 32'h00000000;
            alu_done <= 1'b0;
            alu_res <= 32'h00000000;
        end else begin
            alu_done <= 1'b0;
            alu_res <= ~alu_res;
            if (alu_req) begin
                busy_q <= 1'b1;
                cnt_q <= lat;
                res_q <= alu_opnd.mult_new;
            end else if (busy_q && cnt_q != 8'h00) begin
                cnt_q <= cnt_q - 8'h01;
            end else if (busy_q) begin
                busy_q <= 1'b0;
                alu_done <= 1'b1;
                alu_res <= res_q;
            end
        end
    end
endmodule

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
    import nibble_pkg::*;
    typedef struct packed {
        logic [2:0] src;
        logic [7:0] nib;
        logic [31:0] data;
        logic [31:0] tag;
    } note_t;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic mode_4444 = 1'b0;
    logic fmt_565 = 1'b0;
    logic op_valid = 1'b0;
    op_t op_in = '0;
    logic [31:0] pix_old = 32'h00000000;
    logic [7:0] lat = 8'h00;
    logic clk_en = 1'b1;
    logic op_ready, alu_req, alu_done, rd_valid, reg_rd;
    logic alu_fault, pair_fault, mode_fault;
    logic [31:0] alu_res, rd_data, dirty_tag;
    alu_opnd_t alu_opnd;
    lane_wr_t pix_wr, reg_wr;
    note_t exp_q[$];
    logic [31:0] tag_m = 32'h00000000;
    int bad_count = 0;
    int n_checks = 0;
    int n_pair = 0;

    always #10 clock = ~clock;

    nibble_lane_map #(.DEPTH(8)) uut (.clock, .rst_n, .clk_en,
        .mode_4444, .fmt_565, .op_valid, .op_in, .op_ready, .pix_old,
        .alu_opnd, .alu_req, .alu_done, .alu_res, .pix_wr, .rd_valid,
        .rd_data, .reg_wr, .reg_rd, .dirty_tag, .alu_fault, .pair_fault,
        .mode_fault);
    blend_alu_model alu (.clock, .rst_n, .lat, .alu_req, .alu_opnd,
        .alu_done, .alu_res);

    function automatic logic [7:0] lanes(logic m, logic [3:0] b);
        return m ? {b[3], b[1], b[3], b[1], b[2], b[0], b[2], b[0]}
                 : {b[3], b[3], b[2], b[2], b[1], b[1], b[0], b[0]};
    endfunction

    function automatic logic [31:0] wide(logic [7:0] n);
        logic [31:0] r;
        for (int k = 0; k < 8; k++) r[4*k+:4] = {4{n[k]}};
        return r;
    endfunction

    task automatic check(string what, logic [31:0] e, logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic idle(int n);
        op_valid <= 1'b0;
        repeat (n) @(negedge clock);
    endtask

    // ----
    // Controller side: offer one op, note what must come out
    // ----
    task automatic push(op_kind_t k, logic [2:0] w, logic [3:0] b,
                        logic [31:0] d);
        int i;
        note_t n;
        bit keep;
        logic [3:0] hb;
        i = 0;
        keep = 1'b1;
        op_valid <= 1'b1;
        op_in <= '{k, w, b, d};
        while (op_ready !== 1'b1 && i < 200) begin
            @(negedge clock);
            i++;
        end
        if (i == 200) begin
            bad_count++;
            wrap_up();
        end
        hb = mode_4444 ? {{2{b[3] | b[1]}}, {2{b[2] | b[0]}}} : b;
        n = '{3'd0, lanes(mode_4444, b), d, tag_m};
        if (k inside {K_SF_NORM, K_SF_INIT, K_BLEND} && fmt_565) begin
            n.src = 3'd4;
        end else if (k inside {K_SL_NORM, K_SL_INIT, K_SF_NORM, K_SF_INIT}) begin
            if (k inside {K_SL_INIT, K_SF_INIT}) tag_m = 32'h00000000;
            tag_m[4*w+:4] = tag_m[4*w+:4] | hb;
            if (k inside {K_SF_NORM, K_SF_INIT} && mode_4444)
                n.data = d & wide(n.nib);
        end else if (k == K_READ) begin
            n.src = 3'd1;
            n.data = pix_old & wide(n.nib);
        end else if (k inside {K_CTRL_WR, K_ID_RD}) begin
            n.src = (k == K_CTRL_WR) ? 3'd2 : 3'd3;
            n.nib = lanes(1'b0, b);
        end else begin
            keep = 1'b0;
            if (k == K_TAG_REP) tag_m = d;
            if (k == K_TAG_OR) tag_m = tag_m | d;
        end
        n.tag = tag_m;
        if (keep) exp_q.push_back(n);
        @(negedge clock);
    endtask

    // ----
    // Result watcher
    // ----
    always @(negedge clock) begin
        note_t n;
        logic [2:0] s;
        logic [31:0] sd;
        s = pix_wr.we ? 3'd0 : rd_valid ? 3'd1 : reg_wr.we ? 3'd2 :
            reg_rd ? 3'd3 : 3'd4;
        sd = (s == 3'd0) ? pix_wr.data : (s == 3'd1) ? rd_data : reg_wr.data;
        if (rst_n && pair_fault === 1'b1) n_pair++;
        if (rst_n && (pix_wr.we | rd_valid | reg_wr.we | reg_rd | alu_fault))
        begin
            n = exp_q.size() > 0 ? exp_q.pop_front() : '1;
            check("source", 32'(n.src), 32'(s));
            check("dirty tag", n.tag, dirty_tag);
            if (n.src inside {3'd0, 3'd2, 3'd3}) begin
                check("lanes", 32'(n.nib),
                      32'(s == 3'd0 ? pix_wr.nib_en : reg_wr.nib_en));
            end
            if (n.src < 3'd3) check("data", n.data, sd);
        end
    end

    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        wrap_up();
    end

    initial begin
        int i;
        logic [3:0] b;
        i = $urandom(32'hA5CB8047);
        pix_old = $urandom();
        repeat (12) @(negedge clock);
        rst_n = 1'b1;
        @(negedge clock);
        for (int m = 0; m < 2; m++) begin
            mode_4444 = m[0];
            repeat (3) @(negedge clock);
            for (int r = 0; r < 6; r++) begin
                b = 4'($urandom());
                push(K_SL_NORM, 3'($urandom()), b, $urandom());
                push(K_READ, 3'($urandom()), b, $urandom());
                push(K_SL_INIT, 3'($urandom()), b, $urandom());
                push(K_TAG_OR, 3'h0, b, $urandom());
                push(K_CTRL_WR, 3'h1, b, $urandom());
                push(K_ID_RD, 3'h2, b, $urandom());
                push(K_TAG_REP, 3'h3, b, $urandom());
                push(K_NOP, 3'h4, b, $urandom());
            end
            idle(20);
        end
        // Stateful ops in both modes, one buffer each, then a clash
        for (int j = 0; j < 2; j++) begin
            lat = j ? 8'h1E : 8'h00;
            mode_4444 = j[0];
            push(K_SF_NORM, 3'h6, 4'hC, $urandom());
            push(K_SF_INIT, 3'h7, 4'h3, $urandom());
            push(K_BLEND, 3'h1, 4'hC, $urandom());
            push(K_BLEND, 3'h2, 4'hF, $urandom());
            idle(160);
        end
        // Slow blend holds the head while the queue fills to refusal
        push(K_SF_NORM, 3'h0, 4'h3, $urandom());
        for (i = 0; i < 8; i++) push(K_SL_NORM, 3'(i), 4'hF, $urandom());
        check("ready when full", 32'h0, 32'(op_ready));
        push(K_READ, 3'h2, 4'hF, 32'h00000000);
        idle(100);
        // Frozen clock enable must hold a queued op untouched
        push(K_SL_NORM, 3'h3, 4'h5, $urandom());
        idle(0);
        clk_en = 1'b0;
        repeat (6) @(negedge clock);
        check("frozen note", 32'h1, 32'(exp_q.size()));
        clk_en = 1'b1;
        idle(5);
        // 5-6-5 data stored and read back, blending refused
        mode_4444 = 1'b0;
        fmt_565 = 1'b1;
        repeat (3) @(negedge clock);
        push(K_SL_NORM, 3'h5, 4'hC, $urandom());
        push(K_READ, 3'h5, 4'h3, 32'h00000000);
        push(K_SF_NORM, 3'h5, 4'hC, $urandom());
        push(K_BLEND, 3'h5, 4'h3, $urandom());
        idle(10);
        mode_4444 = 1'b1;
        idle(5);
        check("format clash", 32'h1, 32'(mode_fault));
        fmt_565 = 1'b0;
        idle(10);
        check("notes left", 32'h0, 32'(exp_q.size()));
        check("pair clash", 32'h1, 32'(n_pair));
        wrap_up();
    end
endmodule
